// *** logic/isp_host_end.sv ***
// Host end: drives hard reset, standby, reference clock and serial writes
// Summary of operation
// - Device floats all outputs while reset low
// - Reset low 50 cycles, clock 10 after
// - Clock runs 10 cycles before reset release
// - No serial access within 100 cycles
// - Serial register write starts device soft reset
// - Standby high enters hard standby
// - Standby low resumes normal operation
// - Clock runs 10 cycles after standby rises
// - Clock runs 10 cycles before standby falls
// - Video pins float in reset, driven if used
// - Pins five to two strapped, then float
// - Test reset held negated outside reset
`timescale 1ns/1ps
module isp_host_end #(
   parameter int unsigned REF_HALF_CYC = isp_pkg::REF_HALF,
   parameter logic [7:0] RST_REF = isp_pkg::RST_PULSE_REF,
   parameter logic [7:0] WAIT_REF = isp_pkg::SERIAL_WAIT_REF,
   parameter logic [7:0] STB_AFTER_REF = isp_pkg::STBY_CLK_AFTER_REF,
   parameter logic [7:0] STB_BEFORE_REF = isp_pkg::STBY_CLK_BEFORE_REF
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Pins
   isp_link_if.host link,
   // Commands, one-cycle pulses
   input wire logic cmd_reset,
   input wire logic cmd_soft_reset,
   input wire logic cmd_standby,
   input wire logic cmd_wake,
   // Status
   output logic serial_ready_out,
   output logic standby_out,
   output logic busy_out,
   output logic [7:0] frame_count_out
);
   localparam logic [15:0] DIV_LAST = 16'(REF_HALF_CYC - 1);

   isp_pkg::host_state_e state_r, state_nxt;
   logic [15:0] div_r;
   logic ref_r;
   logic [7:0] cnt_r, cnt_nxt;
   logic waking_r, waking_nxt;
   logic rst_n_r, stby_r, trst_r, wr_r, soft_r;
   logic ready_r, busy_r, stbo_r;
   logic fv_d_r;
   logic [7:0] frames_r;
   logic [7:0] win_r;

   wire tick = (div_r == DIV_LAST);
   wire clk_run = (state_r != isp_pkg::H_STB) | waking_r;
   wire ref_rise = tick & ~ref_r & clk_run;
   wire in_rst = (state_r == isp_pkg::H_RST);
   wire in_ready = (state_r == isp_pkg::H_READY);
   wire fv_seen = link.frame_valid_out & link.video_oe;
   wire fv_rise = fv_seen & ~fv_d_r;

   // Divider next values
   wire [15:0] div_nxt = tick ? 16'h0000 : div_r + 16'h0001;
   wire ref_flip = tick & (clk_run | ref_r);
   // Serial window since hard reset release, second guard for writes
   wire win_done = (win_r > WAIT_REF);
   wire [7:0] win_nxt = !rst_n_r ? 8'h00 : win_r + {7'h00, ref_rise & (win_r != 8'hFF)};
   // Pin next values
   wire rst_n_nxt = (state_nxt != isp_pkg::H_RST);
   wire stby_nxt = (state_nxt == isp_pkg::H_STB_ON) | (state_nxt == isp_pkg::H_STB);
   wire wr_nxt = (state_nxt == isp_pkg::H_SOFT) & in_ready & win_done;
   // Status next values
   wire ready_nxt = (state_nxt == isp_pkg::H_READY);
   wire busy_nxt = ~ready_nxt & (state_nxt != isp_pkg::H_STB);
   wire stbo_nxt = (state_nxt == isp_pkg::H_STB);
   wire [7:0] frames_nxt = in_rst ? 8'h00 : frames_r + {7'h00, fv_rise};

   // Reference clock divider, stops only at low level
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         div_r <= 16'h0000;
         ref_r <= 1'b0;
      end else begin
         div_r <= div_nxt;
         if (ref_flip) ref_r <= ~ref_r;
      end
   end

   always_comb begin
      state_nxt = state_r;
      waking_nxt = waking_r;
      unique case (state_r)
         isp_pkg::H_RST: begin
            // Clock runs for the whole pulse, covering both margins
            if (ref_rise && cnt_r == RST_REF) state_nxt = isp_pkg::H_WAIT;
         end
         isp_pkg::H_WAIT: begin
            if (ref_rise && cnt_r == WAIT_REF) state_nxt = isp_pkg::H_READY;
         end
         isp_pkg::H_READY: begin
            if (cmd_standby) state_nxt = isp_pkg::H_STB_ON;
            else if (cmd_soft_reset) state_nxt = isp_pkg::H_SOFT;
         end
         isp_pkg::H_SOFT: begin
            state_nxt = isp_pkg::H_WAIT;
         end
         isp_pkg::H_STB_ON: begin
            if (ref_rise && cnt_r == STB_AFTER_REF) state_nxt = isp_pkg::H_STB;
         end
         isp_pkg::H_STB: begin
            if (cmd_wake) waking_nxt = 1'b1;
            if (waking_r && ref_rise && cnt_r == STB_BEFORE_REF) begin
               state_nxt = isp_pkg::H_READY;
               waking_nxt = 1'b0;
            end
         end
         default: begin
            state_nxt = isp_pkg::H_RST;
         end
      endcase
      if (cmd_reset && !in_rst) begin
         state_nxt = isp_pkg::H_RST;
         waking_nxt = 1'b0;
      end
   end

   always_comb begin
      if (state_nxt != state_r || (cmd_wake && !waking_r)) cnt_nxt = 8'h00;
      else if (ref_rise && cnt_r != 8'hFF) cnt_nxt = cnt_r + 8'h01;
      else cnt_nxt = cnt_r;
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_r <= isp_pkg::H_RST;
         cnt_r <= 8'h00;
         waking_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         waking_r <= waking_nxt;
      end
   end

   // Reset and standby pins
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rst_n_r <= 1'b0;
         stby_r <= 1'b0;
         trst_r <= 1'b0;
      end else begin
         rst_n_r <= rst_n_nxt;
         stby_r <= stby_nxt;
         trst_r <= rst_n_nxt;
      end
   end

   // Serial write pins
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         wr_r <= 1'b0;
         soft_r <= 1'b0;
      end else begin
         wr_r <= wr_nxt;
         soft_r <= wr_nxt;
      end
   end

   // Serial window counter
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         win_r <= 8'h00;
      end else begin
         win_r <= win_nxt;
      end
   end

   // Status
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ready_r <= 1'b0;
         busy_r <= 1'b1;
         stbo_r <= 1'b0;
      end else begin
         ready_r <= ready_nxt;
         busy_r <= busy_nxt;
         stbo_r <= stbo_nxt;
      end
   end

   // Frame observation
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         fv_d_r <= 1'b0;
         frames_r <= 8'h00;
      end else begin
         fv_d_r <= fv_seen;
         frames_r <= frames_nxt;
      end
   end

   assign link.hard_reset_n = rst_n_r;
   assign link.standby = stby_r;
   assign link.reference_clock_in = ref_r;
   assign link.test_reset_n = trst_r;
   assign link.serial_wr = wr_r;
   assign link.serial_soft_reset = soft_r;
   assign serial_ready_out = ready_r;
   assign standby_out = stbo_r;
   assign busy_out = busy_r;
   assign frame_count_out = frames_r;
endmodule // isp_host_end

// *** logic/isp_pkg.sv ***
// Shared constants and state codes for reset and standby sequencing
package isp_pkg;
   // Reference clock: half period in clk_sys cycles (200 MHz / 10 = 20 MHz)
   localparam int unsigned REF_HALF = 5;
   // Minimum durations in reference clock cycles
   localparam logic [7:0] RST_PULSE_REF = 8'h32;
   localparam logic [7:0] RST_CLK_AFTER_REF = 8'h0A;
   localparam logic [7:0] RST_CLK_BEFORE_REF = 8'h0A;
   localparam logic [7:0] SERIAL_WAIT_REF = 8'h64;
   localparam logic [7:0] STBY_CLK_AFTER_REF = 8'h0A;
   localparam logic [7:0] STBY_CLK_BEFORE_REF = 8'h0A;
   // Device internal durations in reference clock cycles
   localparam logic [7:0] STBY_ENTRY_REF = 8'h10;
   localparam logic [7:0] SOFT_RST_REF = 8'h10;
   localparam logic [7:0] AUTOCFG_REF = 8'h08;
   // Strap fields sampled from the general-purpose pins
   localparam int unsigned STRAP_VIDEO = 0;
   localparam int unsigned STRAP_TRIG = 1;
   localparam int unsigned STRAP_LEVEL = 2;
   localparam int unsigned STRAP_W = 4;
   localparam int unsigned VIDEO_W = 16;
   localparam logic [STRAP_W-1:0] STRAP_RST = 4'h0;

   typedef enum logic [5:0] {
      D_RESET = 6'h01,
      D_DEFAULT = 6'h02,
      D_STREAM = 6'h04,
      D_STBY_ENTER = 6'h08,
      D_STBY = 6'h10,
      D_SOFT = 6'h20
   } dev_state_e;

   typedef enum logic [5:0] {
      H_RST = 6'h01,
      H_WAIT = 6'h02,
      H_READY = 6'h04,
      H_SOFT = 6'h08,
      H_STB_ON = 6'h10,
      H_STB = 6'h20
   } host_state_e;
endpackage

// *** logic/isp_link_if.sv ***
// Pins between host controller and image processor reset block
`timescale 1ns/1ps
interface isp_link_if;
   logic hard_reset_n;
   logic standby;
   logic reference_clock_in;
   logic test_reset_n;
   logic serial_wr;
   logic serial_soft_reset;
   logic [3:0] gpio_in;
   logic [3:0] gpio_out;
   logic [3:0] gpio_oe;
   logic gpio1_out;
   logic gpio1_oe;
   logic trigger_out;
   logic trigger_oe;
   logic frame_valid_out;
   logic line_valid_out;
   logic pixel_clock_out;
   logic [15:0] video_data_out;
   logic video_oe;
   modport dev (
      input hard_reset_n, standby, reference_clock_in, test_reset_n,
      input serial_wr, serial_soft_reset, gpio_in,
      output gpio_out, gpio_oe, gpio1_out, gpio1_oe, trigger_out, trigger_oe,
      output frame_valid_out, line_valid_out, pixel_clock_out, video_data_out, video_oe
   );
   modport host (
      output hard_reset_n, standby, reference_clock_in, test_reset_n,
      output serial_wr, serial_soft_reset,
      input frame_valid_out, video_oe
   );
endinterface

// *** logic/isp_dev_end.sv ***
// Device end: reset, soft reset, standby and pin float control
`timescale 1ns/1ps
module isp_dev_end #(
   parameter logic [7:0] ENTRY_REF = isp_pkg::STBY_ENTRY_REF,
   parameter logic [7:0] SOFT_REF = isp_pkg::SOFT_RST_REF,
   parameter logic [7:0] CFG_REF = isp_pkg::AUTOCFG_REF
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Pins
   isp_link_if.dev link,
   // Firmware pin control
   input wire logic [3:0] fw_gpio_out,
   input wire logic [3:0] fw_gpio_en,
   input wire logic fw_trigger,
   // Status
   output logic [5:0] state_out,
   output logic [3:0] strap_out
);
   isp_pkg::dev_state_e state_r, state_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic ref_d_r;
   logic [3:0] strap_r;
   logic [15:0] pix_r;
   logic vid_oe_r, fv_r, lv_r, pclk_r;
   logic [15:0] data_r;
   logic [3:0] gpio_oe_r, gpio_out_r;
   logic trig_oe_r, trig_r;

   wire ref_rise = link.reference_clock_in & ~ref_d_r;
   wire hard_rst = ~link.hard_reset_n;
   wire soft_req = link.serial_wr & link.serial_soft_reset;
   wire in_dflt = (state_r == isp_pkg::D_DEFAULT);
   wire in_strm = (state_r == isp_pkg::D_STREAM);
   wire active = (state_r == isp_pkg::D_STREAM) | (state_r == isp_pkg::D_STBY_ENTER) |
                 (state_r == isp_pkg::D_STBY);
   wire strap_take = in_dflt & ref_rise & (cnt_r == 8'h00);
   wire level = strap_r[isp_pkg::STRAP_LEVEL];
   wire vid_oe_nxt = in_dflt | (active & strap_r[isp_pkg::STRAP_VIDEO]);
   wire fv_nxt = in_strm ? 1'b1 : level;
   wire lv_nxt = in_strm ? pix_r[3] : level;
   wire pclk_nxt = in_strm ? link.reference_clock_in : level;
   wire [15:0] data_nxt = in_strm ? pix_r : {isp_pkg::VIDEO_W{level}};
   wire [3:0] gpio_oe_nxt = {4{active}} & fw_gpio_en;
   wire trig_oe_nxt = active & strap_r[isp_pkg::STRAP_TRIG];

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         isp_pkg::D_RESET: begin
            state_nxt = isp_pkg::D_DEFAULT;
         end
         isp_pkg::D_DEFAULT: begin
            if (ref_rise && cnt_r == CFG_REF) state_nxt = isp_pkg::D_STREAM;
         end
         isp_pkg::D_STREAM: begin
            if (link.standby) state_nxt = isp_pkg::D_STBY_ENTER;
            else if (soft_req) state_nxt = isp_pkg::D_SOFT;
         end
         isp_pkg::D_STBY_ENTER: begin
            if (!link.standby) state_nxt = isp_pkg::D_STREAM;
            else if (ref_rise && cnt_r == ENTRY_REF) state_nxt = isp_pkg::D_STBY;
         end
         isp_pkg::D_STBY: begin
            if (!link.standby) state_nxt = isp_pkg::D_STREAM;
         end
         isp_pkg::D_SOFT: begin
            if (ref_rise && cnt_r == SOFT_REF) state_nxt = isp_pkg::D_DEFAULT;
         end
         default: begin
            state_nxt = isp_pkg::D_RESET;
         end
      endcase
      if (hard_rst) state_nxt = isp_pkg::D_RESET;
   end

   always_comb begin
      if (state_nxt != state_r) cnt_nxt = 8'h00;
      else if (ref_rise && cnt_r != 8'hFF) cnt_nxt = cnt_r + 8'h01;
      else cnt_nxt = cnt_r;
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_r <= isp_pkg::D_RESET;
         cnt_r <= 8'h00;
         ref_d_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         ref_d_r <= link.reference_clock_in;
      end
   end

   // Strap capture and pixel counter
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         strap_r <= isp_pkg::STRAP_RST;
         pix_r <= 16'h0000;
      end else begin
         if (strap_take) strap_r <= link.gpio_in;
         if (!in_strm) pix_r <= 16'h0000;
         else if (ref_rise) pix_r <= pix_r + 16'h0001;
      end
   end

   // Pin drivers, all floating while held in reset
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         vid_oe_r <= 1'b0;
         fv_r <= 1'b0;
         lv_r <= 1'b0;
         pclk_r <= 1'b0;
         data_r <= 16'h0000;
         gpio_oe_r <= 4'h0;
         gpio_out_r <= 4'h0;
         trig_oe_r <= 1'b0;
         trig_r <= 1'b0;
      end else begin
         vid_oe_r <= vid_oe_nxt & ~hard_rst;
         fv_r <= fv_nxt;
         lv_r <= lv_nxt;
         pclk_r <= pclk_nxt;
         data_r <= data_nxt;
         gpio_oe_r <= gpio_oe_nxt & {4{~hard_rst}};
         gpio_out_r <= fw_gpio_out;
         trig_oe_r <= trig_oe_nxt & ~hard_rst;
         trig_r <= fw_trigger;
      end
   end

   assign link.video_oe = vid_oe_r;
   assign link.frame_valid_out = fv_r;
   assign link.line_valid_out = lv_r;
   assign link.pixel_clock_out = pclk_r;
   assign link.video_data_out = data_r;
   assign link.gpio_oe = gpio_oe_r;
   assign link.gpio_out = gpio_out_r;
   assign link.gpio1_oe = 1'b0;
   assign link.gpio1_out = 1'b0;
   assign link.trigger_oe = trig_oe_r;
   assign link.trigger_out = trig_r;
   assign state_out = state_r;
   assign strap_out = strap_r;
endmodule // isp_dev_end

// *** tb/isp_link_sva.sv ***
// Concurrent checks on the pins between host end and device end
`timescale 1ns/1ps
module isp_link_sva (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Host driven pins
   input wire logic hard_reset_n,
   input wire logic standby,
   input wire logic reference_clock_in,
   input wire logic test_reset_n,
   input wire logic serial_wr,
   input wire logic serial_soft_reset,
   // Device enables
   input wire logic [3:0] gpio_oe,
   input wire logic gpio1_oe,
   input wire logic trigger_oe,
   input wire logic video_oe
);
   logic ref_r;
   logic [7:0] lo_r, hi_r, sb_r, run_r;
   logic [3:0] gap_r;
   wire rise_w = reference_clock_in & ~ref_r;
   wire float_w = ~video_oe & ~trigger_oe & (gpio_oe == 4'h0);
   wire [7:0] inc_w = {7'h00, rise_w};
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         {ref_r, lo_r, hi_r, sb_r, run_r, gap_r} <= '0;
      end else begin
         ref_r <= reference_clock_in;
         lo_r <= hard_reset_n ? 8'h00 : (lo_r == 8'hFF ? lo_r : lo_r + inc_w);
         hi_r <= !hard_reset_n ? 8'h00 : (hi_r == 8'hFF ? hi_r : hi_r + inc_w);
         sb_r <= !standby ? 8'h00 : (sb_r == 8'hFF ? sb_r : sb_r + inc_w);
         run_r <= (gap_r == 4'h8) ? 8'h00 : (run_r == 8'hFF ? run_r : run_r + inc_w);
         gap_r <= rise_w ? 4'h0 : (gap_r == 4'hF ? gap_r : gap_r + 4'h1);
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   a_reset_floats: assert property (!hard_reset_n |=> float_w)
      else $error("pins driven while hard reset low");
   a_pin_one_float: assert property (!gpio1_oe)
      else $error("pin one driven");
   a_reset_width: assert property ($rose(hard_reset_n) |-> lo_r >= 8'h32)
      else $error("hard reset pulse too short");
   a_clock_before: assert property ($rose(hard_reset_n) |-> gap_r < 4'h8 && run_r >= 8'h0A)
      else $error("reference clock idle at reset release");
   a_serial_wait: assert property (serial_wr |-> hi_r >= 8'h64)
      else $error("serial write too early");
   a_soft_floats: assert property (serial_wr && serial_soft_reset |-> ##[1:2] float_w)
      else $error("pins still driven after soft reset write");
   a_strap_float: assert property ($rose(hard_reset_n) |=> (gpio_oe == 4'h0) [*8])
      else $error("strap pins driven after reset");
   a_stby_clock: assert property (standby && gap_r == 4'h8 |-> sb_r >= 8'h0A)
      else $error("clock stopped too soon after standby");
   a_wake_clock: assert property ($fell(standby) |-> run_r >= 8'h0A)
      else $error("standby lowered without clock");
   a_test_negated: assert property (serial_wr || standby |-> test_reset_n)
      else $error("test reset asserted outside reset");
endmodule // isp_link_sva

// *** tb/isp_reset_standby_control_tb.sv ***
// Self-checking bench for both ends of the reset and standby link
`timescale 1ns/1ps
module isp_reset_standby_control_tb;
   logic clk_sys;
   logic resetn;
   logic cmd_reset, cmd_soft_reset, cmd_standby, cmd_wake;
   logic [3:0] fw_gpio_out, fw_gpio_en;
   logic fw_trigger;
   logic [5:0] state_out;
   logic [3:0] strap_out;
   logic serial_ready_out, standby_out, busy_out;
   logic [7:0] frame_count_out;
   int n_fail = 0;
   int check_count = 0;
   int cyc = 0;
   isp_link_if link ();
   isp_dev_end #(.ENTRY_REF(8'h08)) isp_dev_end_i (.clk_sys(clk_sys), .resetn(resetn), .link(link),
      .fw_gpio_out(fw_gpio_out), .fw_gpio_en(fw_gpio_en), .fw_trigger(fw_trigger), .state_out(state_out),
      .strap_out(strap_out));
   isp_host_end #(.REF_HALF_CYC(2)) isp_host_end_i (.clk_sys(clk_sys), .resetn(resetn), .link(link),
      .cmd_reset(cmd_reset), .cmd_soft_reset(cmd_soft_reset), .cmd_standby(cmd_standby), .cmd_wake(cmd_wake),
      .serial_ready_out(serial_ready_out), .standby_out(standby_out), .busy_out(busy_out),
      .frame_count_out(frame_count_out));
   isp_link_sva isp_link_sva_i (.clk_sys(clk_sys), .resetn(resetn), .hard_reset_n(link.hard_reset_n),
      .standby(link.standby), .reference_clock_in(link.reference_clock_in), .test_reset_n(link.test_reset_n),
      .serial_wr(link.serial_wr), .serial_soft_reset(link.serial_soft_reset), .gpio_oe(link.gpio_oe),
      .gpio1_oe(link.gpio1_oe), .trigger_oe(link.trigger_oe), .video_oe(link.video_oe));
   wire [5:0] oe_w = {link.video_oe, link.trigger_oe, link.gpio_oe};

   task automatic give_verdict;
      if (n_fail == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask
   task automatic pulse(input logic [3:0] cmd);
      @(posedge clk_sys);
      #1;
      {cmd_reset, cmd_soft_reset, cmd_standby, cmd_wake} = cmd;
      @(posedge clk_sys);
      #1;
      {cmd_reset, cmd_soft_reset, cmd_standby, cmd_wake} = 4'h0;
   endtask
   task automatic wait_state(input logic [5:0] s);
      for (int i = 0; i < 4000 && state_out !== s; i++) @(posedge clk_sys);
      #1;
   endtask
   task automatic wait_ready;
      for (int i = 0; i < 4000 && serial_ready_out !== 1'b1; i++) @(posedge clk_sys);
      #1;
   endtask
   task automatic t_boot;
      repeat (20) @(posedge clk_sys);
      #1;
      chk(state_out, 6'h01, "state in hard reset");
      chk({oe_w, link.gpio1_oe}, 7'h00, "pins driven in hard reset");
      chk({busy_out, serial_ready_out, link.test_reset_n}, 3'h4, "host status in hard reset");
      wait_ready();
      chk({busy_out, link.test_reset_n, link.hard_reset_n}, 3'h3, "host status when ready");
      chk(state_out, 6'h04, "not streaming after reset");
      chk(strap_out, 4'h3, "straps");
      chk(oe_w, 6'h35, "used pins not driven");
      chk(frame_count_out, 8'h01, "frame count");
   endtask
   task automatic t_video;
      logic [15:0] data0;
      logic pclk0;
      data0 = link.video_data_out;
      repeat (8) @(posedge clk_sys);
      #1;
      chk(link.video_data_out - data0, 16'h0002, "pixel data not counting");
      chk({link.frame_valid_out, link.line_valid_out}, {1'b1, link.video_data_out[3]}, "frame or line valid");
      pclk0 = link.pixel_clock_out;
      repeat (2) @(posedge clk_sys);
      #1;
      chk(link.pixel_clock_out, !pclk0, "pixel clock not toggling");
      chk({link.gpio_out, link.trigger_out, link.gpio1_out}, 6'h26, "firmware pin values");
   endtask
   task automatic t_soft;
      pulse(4'h4);
      wait_state(6'h20);
      chk(state_out, 6'h20, "soft reset not entered");
      chk(oe_w, 6'h00, "pins driven in soft reset");
      wait_ready();
      chk(state_out, 6'h04, "no return after soft reset");
   endtask
   task automatic t_standby;
      pulse(4'h2);
      wait_state(6'h08);
      chk(state_out, 6'h08, "standby entry");
      wait_state(6'h10);
      chk(state_out, 6'h10, "standby not reached");
      chk(oe_w, 6'h35, "used pins not driven in standby");
      for (int i = 0; i < 400 && standby_out !== 1'b1; i++) @(posedge clk_sys);
      repeat (12) @(posedge clk_sys);
      #1;
      chk(link.reference_clock_in, 1'b0, "clock still running in standby");
      chk({busy_out, link.standby, link.frame_valid_out}, 3'h2, "standby status or default level");
      pulse(4'h1);
      wait_ready();
      chk({state_out, standby_out}, 7'h08, "no wake from standby");
   endtask
   task automatic t_hard;
      pulse(4'h8);
      link.gpio_in = 4'h4;
      fw_gpio_en = 4'hA;
      for (int i = 0; i < 100 && link.hard_reset_n !== 1'b0; i++) @(posedge clk_sys);
      repeat (2) @(posedge clk_sys);
      #1;
      chk({state_out, oe_w}, 12'h040, "pins driven after hard reset");
      wait_ready();
      chk(strap_out, 4'h4, "new straps");
      chk(oe_w, 6'h0A, "unused pins driven");
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 12000) begin
         n_fail++;
         give_verdict();
      end
   end
   initial begin
      resetn = 1'b0;
      {cmd_reset, cmd_soft_reset, cmd_standby, cmd_wake} = 4'h0;
      fw_gpio_out = 4'h9;
      fw_gpio_en = 4'h5;
      fw_trigger = 1'b1;
      link.gpio_in = 4'h3;
      repeat (2) @(posedge clk_sys);
      #1;
      resetn = 1'b1;
      t_boot();
      t_video();
      t_soft();
      t_standby();
      t_hard();
      give_verdict();
   end
endmodule // isp_reset_standby_control_tb
